// ---- ees_eeprom_top.sv ----
/*
  Two-wire serial EEPROM slave: 8 KiB array, 32-byte page writes,
  write protect, acknowledge polling during programming.
  Assumes an external master clocks the bus; i_resetn is the power-on
  reset, held low while supply is below the trigger level.
*/
`timescale 1ns/1ns
module ees_eeprom_top
#(
  parameter int unsigned PROG_CYCLES = ees_pkg::PROG_CYC
)
(
  // Clocks and reset
  input  wire logic i_core_clk,
  input  wire logic i_link_clk,
  input  wire logic i_resetn,
  // Two-wire bus
  input  wire logic i_scl,
  input  wire logic i_sda,
  output logic      o_sda_o,
  output logic      o_sda_oe_n,
  // Straps and protect
  input  wire logic i_chip_select_strap_bit0,
  input  wire logic i_chip_select_strap_bit1,
  input  wire logic i_chip_select_strap_bit2,
  input  wire logic i_write_protect
);

  localparam int unsigned CNT_W = $clog2(PROG_CYCLES + 1);

  ees_link_if lnk ();

  ees_link_filter u_filt
  (
    .i_link_clk (i_link_clk),
    .i_resetn   (i_resetn),
    .i_scl      (i_scl),
    .i_sda      (i_sda),
    .o_sda_o    (o_sda_o),
    .o_sda_oe_n (o_sda_oe_n),
    .lnk        (lnk)
  );

  // Synchronisers and edge history
  logic                         scl_m_r;
  logic                         scl_s_r;
  logic                         scl_d_r;
  logic                         sda_m_r;
  logic                         sda_s_r;
  logic                         sda_d_r;
  logic                         wp_m_r;
  logic                         wp_s_r;
  logic [2:0]                   strap_m_r;
  logic [2:0]                   strap_s_r;

  // Engine state
  ees_pkg::ees_state_t          state_r;
  ees_pkg::ees_state_t          state_nxt;
  ees_pkg::ees_phase_t          ph_r;
  ees_pkg::ees_phase_t          ph_nxt;
  logic [3:0]                   bit_r;
  logic [3:0]                   bit_nxt;
  logic [7:0]                   sh_r;
  logic [7:0]                   sh_nxt;
  logic                         low_r;
  logic                         low_nxt;
  logic                         rw_r;
  logic                         rw_nxt;
  logic [ees_pkg::ADDR_W-1:0]   addr_r;
  logic [ees_pkg::ADDR_W-1:0]   addr_nxt;
  logic                         wpc_r;
  logic                         wpc_nxt;
  logic                         got_r;
  logic                         got_nxt;
  logic                         buf_we;
  logic                         buf_clr;

  // Page buffer and programming
  logic [7:0]                   pbuf [ees_pkg::PAGE_BYTES];
  logic [ees_pkg::PAGE_BYTES-1:0] pvalid_r;
  logic [ees_pkg::PAGE_BYTES-1:0] pvalid_nxt;
  logic                         busy_r;
  logic                         busy_nxt;
  logic [CNT_W-1:0]             pcnt_r;
  logic [CNT_W-1:0]             pcnt_nxt;
  logic [7:0]                   mem [ees_pkg::MEM_BYTES] =
    '{default: ees_pkg::ERASED};

  // Decoded conditions
  wire logic                    scl_rise;
  wire logic                    scl_fall;
  wire logic                    start_det;
  wire logic                    stop_det;
  wire logic                    dev_match;
  wire logic                    ack_ok;
  wire logic                    launch;
  wire logic [ees_pkg::OFF_W-1:0] cidx;
  wire logic                    mem_we;
  wire logic [ees_pkg::ADDR_W-1:0] mem_wa;
  wire logic [7:0]              mem_q;
  wire logic [ees_pkg::OFF_W-1:0] off_inc;

  assign scl_rise  = scl_s_r & ~scl_d_r;
  assign scl_fall  = ~scl_s_r & scl_d_r;
  assign start_det = scl_s_r & scl_d_r & sda_d_r & ~sda_s_r;
  assign stop_det  = scl_s_r & scl_d_r & ~sda_d_r & sda_s_r;
  assign dev_match = (sh_r[7:4] == ees_pkg::DEV_TYPE) &&
                     (sh_r[3:1] == strap_s_r) && !busy_r;
  assign ack_ok    = (ph_r == ees_pkg::PH_DEV)  ? dev_match :
                     (ph_r == ees_pkg::PH_DATA) ? ~wpc_r : 1'b1;
  assign launch    = stop_det & got_r & ~wpc_r & ~busy_r;
  assign cidx      = pcnt_r[ees_pkg::OFF_W-1:0];
  assign mem_we    = busy_r && (pcnt_r < CNT_W'(ees_pkg::PAGE_BYTES)) &&
                     pvalid_r[cidx];
  assign mem_wa    = {addr_r[ees_pkg::ADDR_W-1:ees_pkg::OFF_W], cidx};
  assign mem_q     = mem[addr_r];
  assign off_inc   = addr_r[ees_pkg::OFF_W-1:0] + 1'b1;
  assign lnk.drive_low = low_r;

  // Line and strap synchronisers
  always_ff @(posedge i_core_clk)
  begin
    if (!i_resetn)
    begin
      {scl_m_r, scl_s_r, scl_d_r} <= 3'h7;
      {sda_m_r, sda_s_r, sda_d_r} <= 3'h7;
      {wp_m_r, wp_s_r}            <= 2'h0;
      strap_m_r                   <= 3'h0;
      strap_s_r                   <= 3'h0;
    end
    else
    begin
      scl_m_r   <= lnk.scl_lvl;
      scl_s_r   <= scl_m_r;
      scl_d_r   <= scl_s_r;
      sda_m_r   <= lnk.sda_lvl;
      sda_s_r   <= sda_m_r;
      sda_d_r   <= sda_s_r;
      wp_m_r    <= i_write_protect;
      wp_s_r    <= wp_m_r;
      strap_m_r <= {i_chip_select_strap_bit2, i_chip_select_strap_bit1,
                    i_chip_select_strap_bit0};
      strap_s_r <= strap_m_r;
    end
  end

  // Bus engine next state
  always_comb
  begin
    state_nxt = state_r;
    ph_nxt    = ph_r;
    bit_nxt   = bit_r;
    sh_nxt    = sh_r;
    low_nxt   = low_r;
    rw_nxt    = rw_r;
    addr_nxt  = addr_r;
    wpc_nxt   = wpc_r;
    got_nxt   = got_r;
    buf_we    = 1'b0;
    buf_clr   = 1'b0;
    if (stop_det)
    begin
      state_nxt = ees_pkg::ST_IDLE;
      low_nxt   = 1'b0;
      got_nxt   = 1'b0;
    end
    else if (start_det)
    begin
      // Restart without stop abandons any buffered write
      state_nxt = ees_pkg::ST_RX;
      ph_nxt    = ees_pkg::PH_DEV;
      bit_nxt   = 4'h0;
      low_nxt   = 1'b0;
      got_nxt   = 1'b0;
    end
    else
    begin
      case (state_r)
        ees_pkg::ST_IDLE:
          low_nxt = 1'b0;
        ees_pkg::ST_RX:
          if (scl_rise && bit_r != ees_pkg::BITS_PER_BYTE)
          begin
            sh_nxt  = {sh_r[6:0], sda_s_r};
            bit_nxt = bit_r + 1'b1;
          end
          else if (scl_fall && bit_r == ees_pkg::BITS_PER_BYTE)
          begin
            state_nxt = ack_ok ? ees_pkg::ST_ACK : ees_pkg::ST_IDLE;
            low_nxt   = ack_ok;
            case (ph_r)
              ees_pkg::PH_DEV:
              begin
                rw_nxt = sh_r[0];
                ph_nxt = ees_pkg::PH_AHI;
              end
              ees_pkg::PH_AHI:
              begin
                addr_nxt[ees_pkg::ADDR_W-1:8] =
                  sh_r[ees_pkg::HI_ADDR_BITS-1:0];
                ph_nxt = ees_pkg::PH_ALO;
              end
              ees_pkg::PH_ALO:
              begin
                addr_nxt[7:0] = sh_r;
                ph_nxt        = ees_pkg::PH_DATA;
              end
              default:
              begin
                buf_we  = ack_ok;
                got_nxt = got_r | ack_ok;
                if (ack_ok)
                  addr_nxt[ees_pkg::OFF_W-1:0] = off_inc;
              end
            endcase
          end
        ees_pkg::ST_ACK:
          if (scl_fall)
          begin
            bit_nxt = 4'h0;
            low_nxt = 1'b0;
            if (ph_r == ees_pkg::PH_DATA && !got_r)
            begin
              wpc_nxt = wp_s_r;
              buf_clr = 1'b1;
            end
            if (rw_r)
            begin
              sh_nxt    = mem_q;
              addr_nxt  = addr_r + 1'b1;
              low_nxt   = ~mem_q[7];
              state_nxt = ees_pkg::ST_TX;
            end
            else
              state_nxt = ees_pkg::ST_RX;
          end
        ees_pkg::ST_TX:
          if (scl_rise)
            bit_nxt = bit_r + 1'b1;
          else if (scl_fall && bit_r == ees_pkg::BITS_PER_BYTE)
          begin
            low_nxt   = 1'b0;
            state_nxt = ees_pkg::ST_MACK;
          end
          else if (scl_fall)
          begin
            sh_nxt  = {sh_r[6:0], 1'b0};
            low_nxt = ~sh_r[6];
          end
        ees_pkg::ST_MACK:
          if (scl_rise && sda_s_r)
            state_nxt = ees_pkg::ST_IDLE;
          else if (scl_fall)
          begin
            sh_nxt    = mem_q;
            addr_nxt  = addr_r + 1'b1;
            low_nxt   = ~mem_q[7];
            bit_nxt   = 4'h0;
            state_nxt = ees_pkg::ST_TX;
          end
        default:
        begin
          state_nxt = ees_pkg::ST_IDLE;
          low_nxt   = 1'b0;
        end
      endcase
    end
  end

  // Programming sequencer; bytes land during the first 32 busy cycles
  always_comb
  begin
    busy_nxt   = busy_r;
    pcnt_nxt   = pcnt_r;
    pvalid_nxt = pvalid_r;
    if (buf_clr)
      pvalid_nxt = '0;
    if (buf_we)
      pvalid_nxt[addr_r[ees_pkg::OFF_W-1:0]] = 1'b1;
    if (launch)
    begin
      busy_nxt = 1'b1;
      pcnt_nxt = '0;
    end
    else if (busy_r && pcnt_r == CNT_W'(PROG_CYCLES - 1))
      busy_nxt = 1'b0;
    else if (busy_r)
      pcnt_nxt = pcnt_r + 1'b1;
  end

  always_ff @(posedge i_core_clk)
  begin
    if (!i_resetn)
    begin
      state_r  <= ees_pkg::ST_IDLE;
      ph_r     <= ees_pkg::PH_DEV;
      bit_r    <= 4'h0;
      sh_r     <= 8'h00;
      low_r    <= 1'b0;
      rw_r     <= 1'b0;
      addr_r   <= ees_pkg::ADDR_RST;
      wpc_r    <= 1'b0;
      got_r    <= 1'b0;
      busy_r   <= 1'b0;
      pcnt_r   <= '0;
      pvalid_r <= '0;
    end
    else
    begin
      state_r  <= state_nxt;
      ph_r     <= ph_nxt;
      bit_r    <= bit_nxt;
      sh_r     <= sh_nxt;
      low_r    <= low_nxt;
      rw_r     <= rw_nxt;
      addr_r   <= addr_nxt;
      wpc_r    <= wpc_nxt;
      got_r    <= got_nxt;
      busy_r   <= busy_nxt;
      pcnt_r   <= pcnt_nxt;
      pvalid_r <= pvalid_nxt;
    end
  end

  // Storage has no reset: contents survive a brown-out
  always_ff @(posedge i_core_clk)
  begin
    if (buf_we)
      pbuf[addr_r[ees_pkg::OFF_W-1:0]] <= sh_r;
    if (mem_we)
      mem[mem_wa] <= pbuf[cidx];
  end

endmodule

// ---- ees_pkg.sv ----
/*
  Shared constants and types of the serial EEPROM slave.
  Assumes a 10 MHz core clock and a separate link filter clock.
*/
package ees_pkg;

  // Clock rates and times
  localparam int unsigned CLK_MHZ        = 10;
  localparam int unsigned LINK_PERIOD_NS = 6;
  localparam int unsigned FILTER_NS      = 100;
  localparam int unsigned FILT_CYC       =
    (FILTER_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
  localparam int unsigned FILT_W         = 5;
  localparam int unsigned PROG_TIME_US   = 5000;
  localparam int unsigned PROG_CYC       = PROG_TIME_US * CLK_MHZ;

  // Array geometry
  localparam int unsigned ADDR_W     = 13;
  localparam int unsigned MEM_BYTES  = 8192;
  localparam int unsigned OFF_W      = 5;
  localparam int unsigned PAGE_BYTES = 32;
  localparam logic [7:0]  ERASED     = 8'hFF;
  localparam logic [12:0] ADDR_RST   = 13'h0000;

  // Address byte layout
  localparam logic [3:0] DEV_TYPE      = 4'hA;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam int unsigned HI_ADDR_BITS = 5;

  // Which byte of a command is expected next
  typedef enum logic [3:0]
  {
    PH_DEV  = 4'h1,
    PH_AHI  = 4'h2,
    PH_ALO  = 4'h4,
    PH_DATA = 4'h8
  } ees_phase_t;

  // Bus engine states
  typedef enum logic [4:0]
  {
    ST_IDLE = 5'h01,
    ST_RX   = 5'h02,
    ST_ACK  = 5'h04,
    ST_TX   = 5'h08,
    ST_MACK = 5'h10
  } ees_state_t;

endpackage

// ---- ees_link_if.sv ----
/*
  Carrier between the link filter and the command engine.
  Levels only; the receiving side resynchronises each one.
*/
`timescale 1ns/1ns
interface ees_link_if;
  logic scl_lvl;
  logic sda_lvl;
  logic drive_low;

  modport link
  (
    output scl_lvl,
    output sda_lvl,
    input  drive_low
  );

  modport core
  (
    input  scl_lvl,
    input  sda_lvl,
    output drive_low
  );
endinterface

// ---- ees_link_filter.sv ----
/*
  Link-clock front end: synchronises and glitch-filters both bus lines
  and drives the open-drain data pin.
  Assumes i_resetn comes from the core domain and is resynchronised here.
*/
`timescale 1ns/1ns
module ees_link_filter
(
  // Link clock and reset
  input  wire logic i_link_clk,
  input  wire logic i_resetn,
  // Bus pins
  input  wire logic i_scl,
  input  wire logic i_sda,
  output logic      o_sda_o,
  output logic      o_sda_oe_n,
  // Engine side
  ees_link_if.link  lnk
);

  logic       rst_m_r;
  logic       rst_s_r;
  logic       dl_m_r;
  logic       dl_s_r;
  logic [1:0] pins;
  logic [1:0] filt;

  assign pins = {i_sda, i_scl};
  assign lnk.scl_lvl = filt[0];
  assign lnk.sda_lvl = filt[1];

  always_ff @(posedge i_link_clk)
  begin
    rst_m_r <= i_resetn;
    rst_s_r <= rst_m_r;
  end

  // A level must hold past the noise width before it is passed on
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_line
      logic                             m_r;
      logic                             s_r;
      logic                             f_r;
      logic [ees_pkg::FILT_W-1:0]       cnt_r;
      always_ff @(posedge i_link_clk)
      begin
        m_r <= pins[g];
        s_r <= m_r;
        if (!rst_s_r)
        begin
          f_r   <= 1'b1;
          cnt_r <= '0;
        end
        else if (s_r == f_r)
          cnt_r <= '0;
        else if (cnt_r == ees_pkg::FILT_W'(ees_pkg::FILT_CYC - 1))
        begin
          f_r   <= s_r;
          cnt_r <= '0;
        end
        else
          cnt_r <= cnt_r + 1'b1;
      end
      assign filt[g] = f_r;
    end
  endgenerate

  always_ff @(posedge i_link_clk)
  begin
    dl_m_r <= lnk.drive_low;
    dl_s_r <= dl_m_r;
    if (!rst_s_r)
    begin
      o_sda_o    <= 1'b0;
      o_sda_oe_n <= 1'b1;
    end
    else
    begin
      o_sda_o    <= 1'b0;
      o_sda_oe_n <= ~dl_s_r;
    end
  end

endmodule

// ---- ees_eeprom_asserts.sv ----
/*
  Port-level checker of the serial EEPROM slave, bound to its top.
  Assumes bus pins change away from the core clock's rising edge.
*/
`timescale 1ns/1ns
module ees_eeprom_asserts
#(
  parameter int unsigned PROG_CYCLES = 50000
)
(
  input wire logic i_core_clk,
  input wire logic i_link_clk,
  input wire logic i_resetn,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic o_sda_o,
  input wire logic o_sda_oe_n,
  input wire logic i_chip_select_strap_bit0,
  input wire logic i_chip_select_strap_bit1,
  input wire logic i_chip_select_strap_bit2,
  input wire logic i_write_protect
);
  logic        scl_q;
  logic        sda_q;
  logic        frame_r;
  logic        seen_r;
  logic        wr_r;
  logic        dack_r;
  logic        wdat_r;
  logic [3:0]  cnt_r;
  logic [2:0]  byte_r;
  logic [7:0]  sr_r;
  logic [31:0] busy_r;
  wire         rise  = i_scl & ~scl_q & frame_r;
  wire         start = i_scl & scl_q & sda_q & ~i_sda;
  wire         stop  = i_scl & scl_q & ~sda_q & i_sda;
  wire         ninth = rise & (cnt_r == 4'h8);
  wire  [6:0]  own   = {ees_pkg::DEV_TYPE, i_chip_select_strap_bit2,
                        i_chip_select_strap_bit1, i_chip_select_strap_bit0};

  always_ff @(posedge i_core_clk)
  begin
    scl_q <= i_scl;
    sda_q <= i_sda;
    if (rise && !ninth)
      sr_r <= {sr_r[6:0], i_sda};
    if (!i_resetn || start)
    begin
      frame_r <= start;
      seen_r  <= start | (seen_r & i_resetn);
      cnt_r   <= 4'h0;
      byte_r  <= 3'h0;
      wr_r    <= 1'b0;
      dack_r  <= 1'b0;
      wdat_r  <= 1'b0;
    end
    else
    begin
      if (stop)
        frame_r <= 1'b0;
      if (rise)
        cnt_r <= ninth ? 4'h0 : cnt_r + 4'h1;
      if (ninth && byte_r != 3'h7)
        byte_r <= byte_r + 3'h1;
      if (ninth && byte_r == 3'h0)
      begin
        wr_r   <= ~sr_r[0];
        dack_r <= ~i_sda;
      end
      if (ninth && wr_r && byte_r >= 3'h3 && !i_sda)
        wdat_r <= 1'b1;
    end
  end

  // Programming time as seen from the pins; device lags a little
  always_ff @(posedge i_core_clk)
    if (!i_resetn)
      busy_r <= 32'h0;
    else if (stop && wdat_r)
      busy_r <= PROG_CYCLES;
    else if (busy_r != 32'h0)
      busy_r <= busy_r - 32'h1;

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_resetn);

  AST_RESET_IDLE:
    assert property (disable iff (1'b0) !i_resetn [*4] |-> o_sda_oe_n)
    else $error("data pin driven during reset");
  AST_DRIVE_LOW:
    assert property (!o_sda_oe_n |-> o_sda_o == 1'b0)
    else $error("data pin driven high");
  AST_CHANGE_LOW:
    assert property ($changed(o_sda_oe_n) |-> !i_scl)
    else $error("data output changed while clock high");
  AST_NEED_START:
    assert property (!o_sda_oe_n |-> seen_r)
    else $error("data driven before any start");
  AST_STOP_RELEASE:
    assert property (stop |-> o_sda_oe_n [*8])
    else $error("data driven after stop");
  AST_FOREIGN:
    assert property (ninth && byte_r == 3'h0 && sr_r[7:1] != own |-> i_sda)
    else $error("acknowledge to a foreign address");
  AST_HDR_ACK:
    assert property (ninth && wr_r && dack_r &&
                     (byte_r == 3'h1 || byte_r == 3'h2) |-> !i_sda)
    else $error("address byte not acknowledged");
  AST_DATA_ACK:
    assert property (ninth && wr_r && dack_r && byte_r >= 3'h3 &&
                     !i_write_protect |-> !i_sda)
    else $error("data byte not acknowledged");
  AST_WP_REFUSE:
    assert property (ninth && wr_r && dack_r && byte_r == 3'h3 &&
                     i_write_protect |-> i_sda)
    else $error("protected data byte acknowledged");
  AST_BUSY_NACK:
    assert property (ninth && byte_r == 3'h0 && busy_r > 16 |-> i_sda)
    else $error("acknowledge while programming");
endmodule

bind ees_eeprom_top ees_eeprom_asserts #(.PROG_CYCLES(PROG_CYCLES)) chk_u
(
  .i_core_clk               (i_core_clk),
  .i_link_clk               (i_link_clk),
  .i_resetn                 (i_resetn),
  .i_scl                    (i_scl),
  .i_sda                    (i_sda),
  .o_sda_o                  (o_sda_o),
  .o_sda_oe_n               (o_sda_oe_n),
  .i_chip_select_strap_bit0 (i_chip_select_strap_bit0),
  .i_chip_select_strap_bit1 (i_chip_select_strap_bit1),
  .i_chip_select_strap_bit2 (i_chip_select_strap_bit2),
  .i_write_protect          (i_write_protect)
);

// ---- ees_master_model.sv ----
/*
  Two-wire bus master model: drives the clock, releases or pulls data.
  Assumes the bench resolves the data wire with a pull-up.
*/
`timescale 1ns/1ns
module ees_master_model
(
  // Timing reference
  input  wire logic i_clk,
  // Bus
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda_rel
);
  initial
  begin
    o_scl     = 1'b1;
    o_sda_rel = 1'b1;
  end

  task automatic hold(input int n);
    repeat (n) @(negedge i_clk);
  endtask

  // Clock low 1.2 us, well above the slave's answer delay
  task automatic put_bit(input logic b, output logic r);
    hold(6);
    o_sda_rel = b;
    hold(6);
    o_scl = 1'b1;
    hold(6);
    r = i_sda;
    hold(6);
    o_scl = 1'b0;
  endtask

  task automatic start_cond();
    hold(6);
    o_sda_rel = 1'b1;
    hold(6);
    o_scl = 1'b1;
    hold(6);
    o_sda_rel = 1'b0;
    hold(6);
    o_scl = 1'b0;
  endtask

  task automatic stop_cond();
    hold(6);
    o_sda_rel = 1'b0;
    hold(6);
    o_scl = 1'b1;
    hold(6);
    o_sda_rel = 1'b1;
    hold(12);
  endtask

  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      put_bit(d[i], r);
    put_bit(1'b1, r);
    ack = ~r;
  endtask

  task automatic rd_byte(input logic give_ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      put_bit(1'b1, r);
      d[i] = r;
    end
    put_bit(~give_ack, r);
  endtask
endmodule

// ---- test_i2c_serial_eeprom_slave.sv ----
/*
  Self-checking bench of the serial EEPROM slave.
  Assumes the master model and a pull-up on the data wire.
*/
`timescale 1ns/1ns
module test_i2c_serial_eeprom_slave;
  localparam int unsigned PROG  = 1000;
  // Asymmetric straps so a swapped strap order is caught
  localparam logic [2:0]  STRAP = 3'h6;
  localparam logic [7:0]  DEV   = {ees_pkg::DEV_TYPE, STRAP, 1'b0};

  logic       core_clk = 1'b0;
  logic       link_clk = 1'b0;
  logic       resetn   = 1'b0;
  logic       wp       = 1'b0;
  logic       scl;
  logic       sda_rel;
  logic       sda_o;
  logic       sda_oe_n;
  logic [7:0] q [$];
  int         error_cnt = 0;
  int         tests_run = 0;
  wire        sda = sda_rel & (sda_oe_n | sda_o);

  always #50 core_clk = ~core_clk;

  initial
  begin
    #2;
    forever #3 link_clk = ~link_clk;
  end

  ees_eeprom_top #(.PROG_CYCLES(PROG)) dut_u
  (
    .i_core_clk               (core_clk),
    .i_link_clk               (link_clk),
    .i_resetn                 (resetn),
    .i_scl                    (scl),
    .i_sda                    (sda),
    .o_sda_o                  (sda_o),
    .o_sda_oe_n               (sda_oe_n),
    .i_chip_select_strap_bit0 (STRAP[0]),
    .i_chip_select_strap_bit1 (STRAP[1]),
    .i_chip_select_strap_bit2 (STRAP[2]),
    .i_write_protect          (wp)
  );

  ees_master_model mst_u
  (
    .i_clk     (core_clk),
    .i_sda     (sda),
    .o_scl     (scl),
    .o_sda_rel (sda_rel)
  );

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic ack_is(input logic a, input logic e);
    chk({7'h00, a}, {7'h00, e});
  endtask

  task automatic hdr(input logic [7:0] hi, input logic [7:0] lo);
    logic a;
    mst_u.start_cond();
    mst_u.wr_byte(DEV, a);
    ack_is(a, 1'b1);
    mst_u.wr_byte(hi, a);
    ack_is(a, 1'b1);
    mst_u.wr_byte(lo, a);
    ack_is(a, 1'b1);
  endtask

  // Last byte refused to end the read
  task automatic rd_seq(input logic sel, input logic [7:0] hi,
                        input logic [7:0] lo, input int n);
    logic       a;
    logic [7:0] d;
    q.delete();
    if (sel)
      hdr(hi, lo);
    mst_u.start_cond();
    mst_u.wr_byte(DEV | 8'h01, a);
    ack_is(a, 1'b1);
    for (int i = 0; i < n; i++)
    begin
      mst_u.rd_byte(i < n - 1, d);
      q.push_back(d);
    end
    mst_u.stop_cond();
  endtask

  task automatic poll();
    logic a;
    int   tries;
    a = 1'b0;
    tries = 0;
    while (!a && tries < 20)
    begin
      mst_u.start_cond();
      mst_u.wr_byte(DEV, a);
      mst_u.stop_cond();
      tries++;
    end
    ack_is(tries > 1, 1'b1);
    ack_is(a, 1'b1);
  endtask

  task automatic wr_run(input logic [7:0] hi, input logic [7:0] lo,
                        input logic [7:0] base, input int n);
    logic a;
    hdr(hi, lo);
    for (int k = 0; k < n; k++)
    begin
      mst_u.wr_byte(base + k[7:0], a);
      ack_is(a, ~wp);
    end
    mst_u.stop_cond();
    if (!wp)
      poll();
  endtask

  task automatic t_reset();
    ack_is(sda_oe_n, 1'b1);
    ack_is(sda, 1'b1);
  endtask

  task automatic t_erased();
    rd_seq(1'b0, 8'h00, 8'h00, 1);
    chk(q[0], ees_pkg::ERASED);
  endtask

  task automatic t_foreign();
    logic a;
    for (int i = 0; i < 4; i++)
    begin
      mst_u.start_cond();
      mst_u.wr_byte(DEV ^ (i == 0 ? 8'h10 : 8'h01 << i), a);
      mst_u.stop_cond();
      ack_is(a, 1'b0);
    end
    mst_u.wr_byte(DEV, a);
    mst_u.stop_cond();
    ack_is(a, 1'b0);
  endtask

  task automatic t_write();
    wr_run(8'h00, 8'h00, 8'h5A, 1);
    rd_seq(1'b1, 8'h00, 8'h00, 1);
    chk(q[0], 8'h5A);
  endtask

  // 33 bytes from offset 30: the last one lands on offset 30 again
  task automatic t_page();
    logic [7:0] e;
    wr_run(8'hFF, 8'h3E, 8'h00, 33);
    rd_seq(1'b1, 8'h1F, 8'h20, 32);
    for (int o = 0; o < 32; o++)
    begin
      e = (o == 30) ? 8'h20 : 8'((o + 2) % 32);
      chk(q[o], e);
    end
    rd_seq(1'b1, 8'h1F, 8'h3F, 2);
    chk(q[0], 8'h01);
    chk(q[1], ees_pkg::ERASED);
    rd_seq(1'b1, 8'h1F, 8'h1F, 1);
    chk(q[0], ees_pkg::ERASED);
    rd_seq(1'b0, 8'h00, 8'h00, 1);
    chk(q[0], 8'h02);
  endtask

  // Storage keeps its bytes; only the pointer returns to zero
  task automatic t_brownout();
    resetn = 1'b0;
    repeat (16) @(negedge core_clk);
    resetn = 1'b1;
    repeat (20) @(negedge core_clk);
    ack_is(sda_oe_n, 1'b1);
    rd_seq(1'b0, 8'h00, 8'h00, 1);
    chk(q[0], 8'h5A);
  endtask

  task automatic t_wrap();
    rd_seq(1'b1, 8'h1F, 8'hFF, 2);
    chk(q[0], ees_pkg::ERASED);
    chk(q[1], 8'h5A);
  endtask

  task automatic t_protect();
    logic a;
    wp = 1'b1;
    wr_run(8'h00, 8'h00, 8'hA5, 1);
    mst_u.start_cond();
    mst_u.wr_byte(DEV, a);
    mst_u.stop_cond();
    ack_is(a, 1'b1);
    wp = 1'b0;
    rd_seq(1'b1, 8'h00, 8'h00, 1);
    chk(q[0], 8'h5A);
  endtask

  initial
  begin
    repeat (16) @(negedge core_clk);
    resetn = 1'b1;
    repeat (20) @(negedge core_clk);
    t_reset();
    t_erased();
    t_foreign();
    t_write();
    t_page();
    t_wrap();
    t_protect();
    t_brownout();
    wrap_up();
  end

  // Whole sequence needs roughly 30000 cycles
  initial
  begin
    repeat (60000) @(posedge core_clk);
    error_cnt++;
    wrap_up();
  end
endmodule
